// [sltf_fifo.sv]
// Sample FIFO between the sample source and the lane word register.
// Assumes source and drain share the one clock.
module sltf_fifo
  #(parameter int WIDTH = 32,
    parameter int DEPTH = 8)
  (input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic [WIDTH-1:0]      out_data,
   output logic                  out_valid,
   input  wire logic             out_ready);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0]   FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_SLOT  = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  assign out_data = mem[rd_ptr];

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      count     <= next_count;
      in_ready  <= next_count != FULL_COUNT;
      out_valid <= next_count != '0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

endmodule // sltf_fifo

// [sltf_link_test_cfg.sv]
// Serial link test pattern and framing configuration with lane word source.
// Assumes an AHB-Lite master, a sample source and a serializer on one clock.
//
// Notes on behaviour
// (RQ1) Selector zero sends samples; 1,2,3,13,14 send PRBS7,15,23,9,31.
// (RQ2) Selector 4 ramp, 5 transport test pattern, 6 repeated D21.5.
// (RQ3) Selector 7 K28.5, 8 repeated alignment sequence, 9 RPAT, 16 K28.7.
// (RQ4) Selector 10 holds all lane bits low, 11 holds them high.
// (RQ5) Selector 15 sends repeating 16-bit word 0x00ff.
// (RQ6) Software never programs selector 12 or 17 through 31.
// (RQ7) Character, alignment and RPAT patterns only run with 8B/10B coding.
// (RQ8) Software changes test, identifier, comma settings only while disabled.
// (RQ9) Identifier goes out in second alignment multiframe; resets to zero.
// (RQ10) Comma select: 0 K28.7, 1 K28.1, 2 K28.5, 3 reserved.
// (RQ11) Frame-end comma replaces repeated frame-end data, not every frame.
// (RQ12) Comma selection matters only under 8B/10B coding.
// (RQ13) Software keeps comma select zero for compliant receivers.
// (RQ14) Software writes reserved upper bits as zero.
// (RQ15) Any nonzero selection replaces sample payload on every lane word.
//
// Register access over AHB-Lite is this design's own decision.
module sltf_link_test_cfg
  import sltf_pkg::*;
  (input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic [DATA_W-1:0] sample_data,
   input  wire logic              sample_valid,
   output logic                   sample_ready,
   output logic [DATA_W-1:0]      tx_data,
   output logic [K_W-1:0]         tx_k,
   output logic                   tx_valid,
   input  wire logic              tx_ready);

  // ==========================================================================
  // Bus slave
  logic              wr_pend;
  logic              rd_pend;
  logic [11:0]       acc_idx;
  logic [TEST_W-1:0] link_test_select;
  logic [ID_W-1:0]   ila_identifier_value;
  logic [FRAME_END_CHAR_SELECT_W-1:0] frame_end_comma_select;
  logic              serial_link_enable;
  logic              link_mode_select;
  sltf_state_e       state;

  wire        addr_take  = hsel & htrans[1] & hready & (hsize == SIZE_WORD);
  wire [11:0] addr_idx   = haddr[HADDR_LSB +: REG_IDX_W];
  wire        wr_control = wr_pend & (acc_idx == IDX_CONTROL);
  wire        wr_test    = wr_pend & (acc_idx == IDX_TEST_SEL);
  wire        wr_id      = wr_pend & (acc_idx == IDX_ID);
  wire        wr_frame_end_char_select   = wr_pend & (acc_idx == IDX_FRAME_END_CHAR_SELECT);
  wire        link_up    = state == ST_RUN;
  wire [31:0] rd_mux =
      (acc_idx == IDX_CONTROL)  ? {30'h0, link_mode_select, serial_link_enable} :
      (acc_idx == IDX_TEST_SEL) ? {27'h0, link_test_select} :
      (acc_idx == IDX_ID)       ? {24'h0, ila_identifier_value} :
      (acc_idx == IDX_FRAME_END_CHAR_SELECT)    ? {30'h0, frame_end_comma_select} :
      (acc_idx == IDX_STATUS)   ? {25'h0, link_up, 6'h0} :
      32'h0;

  // Reads take one wait state so data written just before is seen
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      wr_pend   <= 1'b0;
      rd_pend   <= 1'b0;
      acc_idx   <= '0;
      hreadyout <= 1'b1;
      hrdata    <= '0;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend <= addr_take & hwrite;
      rd_pend <= addr_take & ~hwrite;
      if (addr_take)
        acc_idx <= addr_idx;
      hreadyout <= ~(addr_take & ~hwrite);
      if (rd_pend)
        hrdata <= rd_mux;
    end
  end

  // Upper bits are dropped on write, so they always read back zero
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      serial_link_enable     <= 1'b0;
      link_mode_select       <= 1'b0;
      link_test_select       <= TEST_RESET;
      ila_identifier_value   <= ID_RESET; // RQ9
      frame_end_comma_select <= FRAME_END_CHAR_SELECT_RESET;
    end
    else
    begin
      if (wr_control)
      begin
        serial_link_enable <= hwdata[ENABLE_BIT];
        link_mode_select   <= hwdata[MODE_BIT];
      end
      if (wr_test)
        link_test_select <= hwdata[TEST_W-1:0];
      if (wr_id)
        ila_identifier_value <= hwdata[ID_W-1:0];
      if (wr_frame_end_char_select)
        frame_end_comma_select <= hwdata[FRAME_END_CHAR_SELECT_W-1:0];
    end
  end

  // ==========================================================================
  // Sample FIFO and PRBS source
  logic [DATA_W-1:0] fifo_data;
  logic              fifo_valid;
  logic [31:0]       prbs_word;
  logic [15:0]       pat_cnt;
  logic [2:0]        word_cnt;
  logic [1:0]        mf_cnt;
  logic [0:0]        frame_cnt;
  logic [7:0]        last_byte;
  logic              test_q_valid;
  logic [TEST_W-1:0] test_q;

  wire mode_8b10b  = ~link_mode_select;
  wire load        = ~tx_valid | tx_ready;
  wire sel_normal  = link_test_select == SEL_NORMAL;
  wire fifo_ready  = load & (state == ST_RUN) & sel_normal;
  wire prbs_restart = (state == ST_IDLE) | (test_q != link_test_select) | ~test_q_valid;

  wire [4:0] prbs_len =
      (link_test_select == SEL_PRBS7)  ? 5'd7  :
      (link_test_select == SEL_PRBS9)  ? 5'd9  :
      (link_test_select == SEL_PRBS15) ? 5'd15 :
      (link_test_select == SEL_PRBS23) ? 5'd23 : 5'd31;
  wire [4:0] prbs_tap =
      (link_test_select == SEL_PRBS7)  ? 5'd6  :
      (link_test_select == SEL_PRBS9)  ? 5'd5  :
      (link_test_select == SEL_PRBS15) ? 5'd14 :
      (link_test_select == SEL_PRBS23) ? 5'd18 : 5'd28;

  sltf_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (.clock     (clock),
     .reset     (reset),
     .in_data   (sample_data),
     .in_valid  (sample_valid),
     .in_ready  (sample_ready),
     .out_data  (fifo_data),
     .out_valid (fifo_valid),
     .out_ready (fifo_ready));

  // ==========================================================================
  // Lane word selection
  logic [DATA_W-1:0] next_data;
  logic [K_W-1:0]    next_k;
  logic              next_valid;

  wire        frame_end  = frame_cnt == FRAME_LAST;
  wire [7:0]  comma_char = (frame_end_comma_select == 2'h1) ? CH_K28_1 :
                           (frame_end_comma_select == 2'h2) ? CH_K28_5 : CH_K28_7; // RQ10
  // Substitute only when the frame-end byte repeats the previous frame's
  wire        comma_hit  = mode_8b10b & frame_end & (fifo_data[31:24] == last_byte); // RQ11 RQ12
  wire [31:0] ila_word   = {(word_cnt == MF_LAST) ? CH_K28_3 : 8'h00,
                            (mf_cnt == ILA_MF_ID && word_cnt == '0) ? ila_identifier_value : 8'h00,
                            (mf_cnt == ILA_MF_ID && word_cnt == '0) ? CH_K28_4 : 8'h00,
                            (word_cnt == '0) ? CH_K28_0 : 8'h00}; // RQ9
  wire [3:0]  ila_k      = {word_cnt == MF_LAST, 1'b0,
                            mf_cnt == ILA_MF_ID && word_cnt == '0, word_cnt == '0};
  wire [7:0]  rb         = pat_cnt[7:0];
  wire [31:0] ramp_word  = {rb + 8'h03, rb + 8'h02, rb + 8'h01, rb};
  wire [31:0] transp_word = {pat_cnt + 16'h0001, pat_cnt};
  wire [15:0] pat_step   = (link_test_select == SEL_RAMP)   ? RAMP_STEP :
                           (link_test_select == SEL_TRANSP) ? TRANSP_STEP : RPAT_STEP;

  always_comb
  begin
    next_data  = ALL_LOW;
    next_k     = K_NONE;
    next_valid = state != ST_IDLE;
    if (state == ST_ILA)
    begin
      next_data = ila_word;
      next_k    = ila_k;
    end
    else if (state == ST_RUN)
    begin
      unique case (link_test_select)
        SEL_NORMAL:
        begin
          next_valid = fifo_valid;
          next_data  = comma_hit ? {comma_char, fifo_data[23:0]} : fifo_data;
          next_k     = {comma_hit, 3'h0};
        end
        SEL_PRBS7, SEL_PRBS9, SEL_PRBS15, SEL_PRBS23, SEL_PRBS31:
          next_data = prbs_word; // RQ1 RQ15
        SEL_RAMP:   next_data = ramp_word; // RQ2
        SEL_TRANSP: next_data = transp_word; // RQ2
        SEL_D21_5:  next_data = {4{CH_D21_5}}; // RQ2
        SEL_K28_5, SEL_K28_7:
        begin
          // Character patterns idle low in 64B/66B coding
          if (mode_8b10b) // RQ7
          begin
            next_data = {4{(link_test_select == SEL_K28_5) ? CH_K28_5 : CH_K28_7}}; // RQ3
            next_k    = K_ALL;
          end
        end
        SEL_RPAT:
          if (mode_8b10b) // RQ7
            next_data = RPAT_TABLE[pat_cnt[1:0]]; // RQ3
        SEL_ILA:    next_data = ALL_LOW;
        SEL_LOW:    next_data = ALL_LOW; // RQ4
        SEL_HIGH:   next_data = ALL_HIGH; // RQ4
        SEL_CLOCK:  next_data = {2{CLOCK_WORD}}; // RQ5
        default:    next_data = ALL_LOW;
      endcase
    end
  end

  wire adv = load & next_valid;

  sltf_prbs u_prbs
    (.clock   (clock),
     .reset   (reset),
     .restart (prbs_restart),
     .advance (adv),
     .length  (prbs_len),
     .tap     (prbs_tap),
     .word    (prbs_word));

  // ==========================================================================
  // Sequencing
  wire        mf_done  = word_cnt == MF_LAST;
  wire        ila_done = mf_done & (mf_cnt == ILA_MF_LAST);
  wire        ila_wanted = mode_8b10b & (sel_normal | (link_test_select == SEL_ILA)); // RQ3 RQ7
  sltf_state_e next_state;

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (serial_link_enable)
          next_state = ila_wanted ? ST_ILA : ST_RUN;
      ST_ILA:
        if (!serial_link_enable)
          next_state = ST_IDLE;
        else if (adv && ila_done && link_test_select != SEL_ILA)
          next_state = ST_RUN;
      ST_RUN:
        if (!serial_link_enable)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock)
  begin
    if (reset || state == ST_IDLE)
    begin
      word_cnt  <= '0;
      mf_cnt    <= '0;
      frame_cnt <= '0;
      pat_cnt   <= '0;
      last_byte <= '0;
    end
    else if (adv)
    begin
      word_cnt  <= word_cnt + 1'b1;
      frame_cnt <= frame_cnt + 1'b1;
      pat_cnt   <= pat_cnt + pat_step;
      if (mf_done)
        mf_cnt <= mf_cnt + 1'b1;
      if (state == ST_RUN && sel_normal && frame_end)
        last_byte <= fifo_data[31:24];
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      test_q       <= TEST_RESET;
      test_q_valid <= 1'b0;
      tx_data      <= ALL_LOW;
      tx_k         <= K_NONE;
      tx_valid     <= 1'b0;
    end
    else
    begin
      test_q       <= link_test_select;
      test_q_valid <= 1'b1;
      if (load)
      begin
        tx_data  <= next_data;
        tx_k     <= next_k;
        tx_valid <= next_valid;
      end
    end
  end

  // ==========================================================================
  // Checks
  wire run_load = load & (state == ST_RUN);

  low_level_a: assert property (@(posedge clock) disable iff (reset) // RQ4
    run_load && link_test_select == SEL_LOW |=> tx_data == ALL_LOW && tx_valid)
    else $error("low pattern not all zero");
  high_level_a: assert property (@(posedge clock) disable iff (reset) // RQ4
    run_load && link_test_select == SEL_HIGH |=> tx_data == ALL_HIGH && tx_k == K_NONE)
    else $error("high pattern not all ones");
  clock_word_a: assert property (@(posedge clock) disable iff (reset) // RQ5
    run_load && link_test_select == SEL_CLOCK |=> tx_data == 32'h00ff_00ff)
    else $error("clock pattern wrong");
  d21_char_a: assert property (@(posedge clock) disable iff (reset) // RQ2
    run_load && link_test_select == SEL_D21_5 |=> tx_data == 32'hb5b5_b5b5 && tx_k == K_NONE)
    else $error("D21.5 pattern wrong");
  k_chars_a: assert property (@(posedge clock) disable iff (reset) // RQ3
    run_load && mode_8b10b && link_test_select == SEL_K28_7 |=> tx_k == K_ALL
    && tx_data == 32'hfcfc_fcfc)
    else $error("K28.7 pattern wrong");
  coding_guard_a: assert property (@(posedge clock) disable iff (reset) // RQ7
    run_load && !mode_8b10b && link_test_select == SEL_K28_5 |=> tx_k == K_NONE
    && tx_data == ALL_LOW)
    else $error("8B/10B pattern sent in 64B/66B coding");
  ramp_step_a: assert property (@(posedge clock) disable iff (reset) // RQ2
    run_load && link_test_select == SEL_RAMP ##1 run_load && link_test_select == SEL_RAMP
    |=> tx_data[7:0] == $past(tx_data[7:0]) + 8'h04)
    else $error("ramp does not step by four");
  ila_ident_a: assert property (@(posedge clock) disable iff (reset) // RQ9
    load && state == ST_ILA && mf_cnt == ILA_MF_ID && word_cnt == '0
    |=> tx_data[23:16] == $past(ila_identifier_value) && tx_k == 4'h3)
    else $error("identifier missing from second multiframe");
  comma_mode_a: assert property (@(posedge clock) disable iff (reset) // RQ12
    run_load && sel_normal && !mode_8b10b |=> tx_k == K_NONE)
    else $error("comma inserted in 64B/66B coding");
  sample_pass_a: assert property (@(posedge clock) disable iff (reset) // RQ15
    fifo_ready && fifo_valid && !comma_hit |=> tx_data == $past(fifo_data))
    else $error("sample word altered");

endmodule // sltf_link_test_cfg

// [sltf_pkg.sv]
// Constants shared by the serial link test and framing block.
// Assumes one 50 MHz clock and a 32-bit lane word of four characters.
package sltf_pkg;

  // ==========================================================================
  // Register map (indices; byte address is four times the index)
  localparam int          REG_IDX_W     = 12;
  localparam int          HADDR_LSB     = 2;
  localparam logic [11:0] IDX_CONTROL   = 12'h200;
  localparam logic [11:0] IDX_TEST_SEL  = 12'h205;
  localparam logic [11:0] IDX_ID        = 12'h206;
  localparam logic [11:0] IDX_FRAME_END_CHAR_SELECT     = 12'h207;
  localparam logic [11:0] IDX_STATUS    = 12'h208;
  localparam int          TEST_W        = 5;
  localparam int          ID_W          = 8;
  localparam int          FRAME_END_CHAR_SELECT_W       = 2;
  localparam logic [4:0]  TEST_RESET    = 5'h00;
  localparam logic [7:0]  ID_RESET      = 8'h00;
  localparam logic [1:0]  FRAME_END_CHAR_SELECT_RESET   = 2'h0;
  localparam int          ENABLE_BIT    = 0;
  localparam int          MODE_BIT      = 1;
  localparam int          LINK_UP_BIT   = 6;
  localparam logic [2:0]  SIZE_WORD     = 3'h2;

  // ==========================================================================
  // Test selector codes
  localparam logic [4:0] SEL_NORMAL = 5'h00;
  localparam logic [4:0] SEL_PRBS7  = 5'h01;
  localparam logic [4:0] SEL_PRBS15 = 5'h02;
  localparam logic [4:0] SEL_PRBS23 = 5'h03;
  localparam logic [4:0] SEL_RAMP   = 5'h04;
  localparam logic [4:0] SEL_TRANSP = 5'h05;
  localparam logic [4:0] SEL_D21_5  = 5'h06;
  localparam logic [4:0] SEL_K28_5  = 5'h07;
  localparam logic [4:0] SEL_ILA    = 5'h08;
  localparam logic [4:0] SEL_RPAT   = 5'h09;
  localparam logic [4:0] SEL_LOW    = 5'h0a;
  localparam logic [4:0] SEL_HIGH   = 5'h0b;
  localparam logic [4:0] SEL_PRBS9  = 5'h0d;
  localparam logic [4:0] SEL_PRBS31 = 5'h0e;
  localparam logic [4:0] SEL_CLOCK  = 5'h0f;
  localparam logic [4:0] SEL_K28_7  = 5'h10;

  // ==========================================================================
  // Characters and patterns
  localparam logic [7:0]  CH_D21_5    = 8'hb5;
  localparam logic [7:0]  CH_K28_0    = 8'h1c;
  localparam logic [7:0]  CH_K28_1    = 8'h3c;
  localparam logic [7:0]  CH_K28_3    = 8'h7c;
  localparam logic [7:0]  CH_K28_4    = 8'h9c;
  localparam logic [7:0]  CH_K28_5    = 8'hbc;
  localparam logic [7:0]  CH_K28_7    = 8'hfc;
  localparam logic [15:0] CLOCK_WORD  = 16'h00ff;
  localparam logic [31:0] ALL_LOW     = 32'h0000_0000;
  localparam logic [31:0] ALL_HIGH    = 32'hffff_ffff;
  localparam logic [3:0]  K_NONE      = 4'h0;
  localparam logic [3:0]  K_ALL       = 4'hf;
  localparam logic [31:0] RPAT_TABLE [4] = '{32'hbe_d7_23_47, 32'h6b_8f_b3_14,
                                             32'h5e_fb_35_59, 32'hbe_d7_23_47};
  localparam logic [15:0] RAMP_STEP   = 16'h0004;
  localparam logic [15:0] TRANSP_STEP = 16'h0002;
  localparam logic [15:0] RPAT_STEP   = 16'h0001;

  // ==========================================================================
  // Framing and data path
  localparam int         DATA_W      = 32;
  localparam int         K_W         = 4;
  localparam int         FIFO_DEPTH  = 8;
  localparam logic [0:0] FRAME_LAST  = 1'h1;
  localparam logic [2:0] MF_LAST     = 3'h7;
  localparam logic [1:0] ILA_MF_LAST = 2'h3;
  localparam logic [1:0] ILA_MF_ID   = 2'h1;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ILA  = 3'b010,
    ST_RUN  = 3'b100
  } sltf_state_e;

endpackage

// [sltf_prbs.sv]
// Fibonacci PRBS generator, 32 bits per advance, length and tap selectable.
// Assumes the caller restarts it whenever the polynomial changes.
module sltf_prbs
  (input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        restart,
   input  wire logic        advance,
   input  wire logic [4:0]  length,
   input  wire logic [4:0]  tap,
   output logic [31:0]      word);

  logic [30:0] state;
  logic [30:0] next_state;

  always_comb
  begin
    logic [30:0] s;
    logic        fb;
    s  = state;
    fb = 1'b0;
    for (int i = 0; i < 32; i++)
    begin
      fb      = s[length - 5'h01] ^ s[tap - 5'h01];
      word[i] = fb;
      s       = {s[29:0], fb};
    end
    next_state = s;
  end

  always_ff @(posedge clock)
  begin
    // All ones is a legal seed for every supported length
    if (reset || restart)
      state <= '1;
    else if (advance)
      state <= next_state;
  end

endmodule // sltf_prbs

// [sltf_rx_model.sv]
// Receiver stand-in for the lane output: accepts words, records them in order.
// Assumes the lane handshake of the link block and the one bench clock.
module sltf_rx_model
  import sltf_pkg::*;
  (input  wire logic              clock,
   input  wire logic              reset,
   input  wire logic [DATA_W-1:0] tx_data,
   input  wire logic [K_W-1:0]    tx_k,
   input  wire logic              tx_valid,
   output logic                   tx_ready);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Capture
  logic [35:0] q [$];
  logic [1:0]  ph;

  // Refuses one cycle in four so that held lane words are exercised
  always @(posedge clock)
  begin
    if (reset)
    begin
      ph <= 2'h0;
      tx_ready <= 1'b0;
    end
    else
    begin
      if (tx_valid && tx_ready)
        q.push_back({tx_k, tx_data});
      tx_ready <= (ph != 2'h3);
      ph <= ph + 2'h1;
    end
  end
endmodule // sltf_rx_model

// [tb_serial_link_test_and_framing_cfg.sv]
// Testbench: register access over the bus, pattern, alignment and framing checks.
// Assumes the package, design files and receiver model are compiled first.
module tb_serial_link_test_and_framing_cfg
  import sltf_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Signals and instances
  logic        clock, reset, hsel, hwrite, hreadyout, hresp;
  logic        sample_valid, sample_ready, tx_valid, tx_ready;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  tx_k;
  logic [31:0] haddr, hwdata, hrdata, sample_data, tx_data, r;
  logic [4:0]  sels [9];
  logic [4:0]  prbs [5];
  int          plen [5] = '{7, 15, 23, 9, 31};
  int          ptap [5] = '{6, 14, 18, 5, 28};
  int          err_total, n_checks;

  sltf_link_test_cfg i_dut (.clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .tx_data(tx_data),
    .tx_k(tx_k), .tx_valid(tx_valid), .tx_ready(tx_ready));
  sltf_rx_model i_rx (.clock(clock), .reset(reset), .tx_data(tx_data), .tx_k(tx_k),
    .tx_valid(tx_valid), .tx_ready(tx_ready));

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [35:0] g, input logic [35:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  // One single word transfer; read data lands in r
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'b00};
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({35'h0, hresp}, 36'h0, "bus response");
  endtask

  // Sample stream: n words in order, each held until the buffer takes it
  task automatic feed(input int n);
    sample_valid <= 1'b1;
    for (int k = 0; k < n; k++)
    begin
      sample_data <= smp(k);
      do @(posedge clock); while (sample_ready !== 1'b1);
    end
    sample_valid <= 1'b0;
    sample_data <= ~smp(n - 1);
  endtask

  // Reference sequence from an all-ones seed, oldest new bit in bit 0
  function automatic logic [31:0] prbsw(input int len, input int tap, input int j);
    logic [30:0] s;
    logic [31:0] w;
    s = '1;
    w = '0;
    for (int n = 0; n <= j; n++)
      for (int i = 0; i < 32; i++)
      begin
        w[i] = s[len - 1] ^ s[tap - 1];
        s = {s[29:0], w[i]};
      end
    return w;
  endfunction

  task automatic run(input logic [4:0] s, input logic m, input int n);
    bus(1'b1, IDX_CONTROL, 32'h0);
    repeat (4) @(posedge clock);
    i_rx.q.delete();
    bus(1'b1, IDX_TEST_SEL, {27'h0, s});
    bus(1'b1, IDX_CONTROL, {30'h0, m, 1'b1});
    while (i_rx.q.size() < n) @(posedge clock);
  endtask

  function automatic logic [35:0] expw(input logic [4:0] s, input int j);
    logic [7:0] b;
    b = 8'(4 * j);
    case (s)
      SEL_LOW:    return {K_NONE, ALL_LOW};
      SEL_HIGH:   return {K_NONE, ALL_HIGH};
      SEL_CLOCK:  return {K_NONE, {2{CLOCK_WORD}}};
      SEL_RAMP:   return {K_NONE, b + 8'h3, b + 8'h2, b + 8'h1, b};
      SEL_TRANSP: return {K_NONE, 16'(2 * j + 1), 16'(2 * j)};
      SEL_D21_5:  return {K_NONE, {4{CH_D21_5}}};
      SEL_K28_5:  return {K_ALL, {4{CH_K28_5}}};
      SEL_RPAT:   return {K_NONE, RPAT_TABLE[j % 4]};
      default:    return {K_ALL, {4{CH_K28_7}}};
    endcase
  endfunction

  // Words 1 and 3 share a top byte, so only word 3 may carry the frame-end comma
  function automatic logic [31:0] smp(input int k);
    return {8'h10 + 8'(k == 3 ? 1 : k), 24'(k)};
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and tests
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    #400000;
    err_total++;
    conclude();
  end

  initial
  begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = SIZE_WORD;
    sample_data = 32'h0;
    sample_valid = 1'b0;
    err_total = 0;
    n_checks = 0;
    sels = '{SEL_LOW, SEL_HIGH, SEL_CLOCK, SEL_RAMP, SEL_TRANSP, SEL_D21_5, SEL_K28_5,
             SEL_RPAT, SEL_K28_7};
    prbs = '{SEL_PRBS7, SEL_PRBS15, SEL_PRBS23, SEL_PRBS9, SEL_PRBS31};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    bus(1'b0, IDX_ID, 32'h0);
    chk({4'h0, r}, 36'h0, "identifier reset");
    bus(1'b0, IDX_FRAME_END_CHAR_SELECT, 32'h0);
    chk({4'h0, r}, 36'h0, "comma select reset");
    bus(1'b0, IDX_TEST_SEL, 32'h0);
    chk({4'h0, r}, 36'h0, "selector reset");
    bus(1'b0, 12'h3ff, 32'h0);
    chk({4'h0, r}, 36'h0, "unmapped read");
    bus(1'b1, IDX_ID, 32'ha5);
    bus(1'b1, IDX_FRAME_END_CHAR_SELECT, 32'h1);
    bus(1'b0, IDX_ID, 32'h0);
    chk({4'h0, r}, 36'ha5, "identifier readback");
    bus(1'b0, IDX_FRAME_END_CHAR_SELECT, 32'h0);
    chk({4'h0, r}, 36'h1, "comma select readback");
    foreach (sels[i])
    begin
      run(sels[i], 1'b0, 4);
      for (int j = 0; j < 4; j++)
        chk(i_rx.q[j], expw(sels[i], j), "pattern word");
    end
    bus(1'b0, IDX_STATUS, 32'h0);
    chk({4'h0, r}, 36'(32'h1 << LINK_UP_BIT), "link up flag");
    foreach (prbs[i])
    begin
      run(prbs[i], 1'b0, 2);
      chk(36'(i_rx.q[0] !== i_rx.q[1] && i_rx.q[1][35:32] === K_NONE), 36'h1, "prbs");
      chk(i_rx.q[1], {K_NONE, prbsw(plen[i], ptap[i], 1)}, "prbs word");
    end
    run(SEL_K28_5, 1'b1, 2);
    chk(i_rx.q[1], 36'h0, "character pattern in 64b66b");
    run(SEL_ILA, 1'b0, 40);
    chk(i_rx.q[32], {4'h1, 24'h0, CH_K28_0}, "alignment repeats");
    // Fill the buffer while the link is off, then let the alignment run drain it
    bus(1'b1, IDX_CONTROL, 32'h0);
    repeat (4) @(posedge clock);
    i_rx.q.delete();
    bus(1'b1, IDX_TEST_SEL, 32'h0);
    feed(8);
    repeat (2) @(posedge clock);
    chk(36'(sample_ready), 36'h0, "buffer full");
    bus(1'b1, IDX_CONTROL, 32'h1);
    while (i_rx.q.size() < 40) @(posedge clock);
    chk(36'({i_rx.q[0][32], i_rx.q[0][7:0]}), 36'({1'b1, CH_K28_0}), "alignment start");
    chk(36'({i_rx.q[8][33], i_rx.q[8][23:8]}), 36'({1'b1, 8'ha5, CH_K28_4}), "ident");
    chk(36'({i_rx.q[31][35], i_rx.q[31][31:24]}), 36'({1'b1, CH_K28_3}), "alignment end");
    for (int k = 0; k < 8; k++)
      chk(i_rx.q[32 + k], k == 3 ? {4'h8, CH_K28_1, 24'h3} : {K_NONE, smp(k)}, "sample");
    chk(36'(sample_ready), 36'h1, "buffer drained");
    // Word 3 would take a comma in 8B/10B coding; none may appear here
    run(SEL_NORMAL, 1'b1, 0);
    feed(4);
    while (i_rx.q.size() < 4) @(posedge clock);
    for (int k = 0; k < 4; k++)
      chk(i_rx.q[k], {K_NONE, smp(k)}, "sample in 64b66b");
    conclude();
  end
endmodule // tb_serial_link_test_and_framing_cfg
